//--- branch_defines.svh
// Constants for the conditional relative-branch unit.
// Assumes inclusion by bare name from the package and the modules.
`ifndef BRANCH_DEFINES_SVH
`define BRANCH_DEFINES_SVH

// Status register bit positions
`define SR_CARRY_BIT      0
`define SR_ZERO_BIT       1
`define SR_NEGATIVE_BIT   2
`define SR_OVERFLOW_BIT   3
`define SR_SIGN_BIT       4
`define SR_HALF_CARRY_BIT 5
`define SR_TRANSFER_BIT   6
`define SR_INTERRUPT_BIT  7

// Widths and defaults
`define PC_WIDTH_DEFAULT     16
`define OFFSET_WIDTH_DEFAULT 7
`define PC_RESET_VALUE       16'h0000

// Cycle counts of a branch
`define CYCLES_NOT_TAKEN 1
`define CYCLES_TAKEN     2

`endif

//--- branch_pkg.sv
// Types shared by the conditional relative-branch unit.
// Assumes branch_defines.svh sits in the include path.
`default_nettype none
`include "branch_defines.svh"

package branch_pkg;

    // Branch operations handled by this unit
    typedef enum logic [3:0] {
        OP_NONE,
        OP_BRANCH_CARRY_SET,
        OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_OR_HIGHER,
        OP_BRANCH_UNSIGNED_LOWER,
        OP_BRANCH_NEGATIVE,
        OP_BRANCH_POSITIVE,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_CARRY_SET,
        OP_BRANCH_HALF_CARRY_CLEAR,
        OP_BRANCH_TRANSFER_BIT_SET,
        OP_BRANCH_TRANSFER_BIT_CLEAR,
        OP_BRANCH_OVERFLOW_SET
    } branch_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TAKEN_SECOND
    } branch_state_t;

endpackage : branch_pkg

`default_nettype wire

//--- branch_cond_if.sv
// Interface between the branch sequencer and the condition evaluator.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none

interface branch_cond_if;
    import branch_pkg::*;
    branch_op_t op;
    logic [7:0] status;
    logic       is_branch;
    logic       taken;

    modport requester (output op, output status, input is_branch, input taken);
    modport evaluator (input op, input status, output is_branch, output taken);
endinterface : branch_cond_if

`default_nettype wire

//--- branch_cond_eval.sv
// Condition evaluator: decides from the status flags whether a branch is taken.
// Assumes the status byte is the live status register of the core.
`timescale 1ns/100ps
`default_nettype none
`include "branch_defines.svh"

module branch_cond_eval
    import branch_pkg::*;
(
    branch_cond_if.evaluator cond
);

    logic c_flag;
    logic n_flag;
    logic v_flag;
    logic h_flag;
    logic t_flag;

    // Flag extraction
    assign c_flag = cond.status[`SR_CARRY_BIT];
    assign n_flag = cond.status[`SR_NEGATIVE_BIT];
    assign v_flag = cond.status[`SR_OVERFLOW_BIT];
    assign h_flag = cond.status[`SR_HALF_CARRY_BIT];
    assign t_flag = cond.status[`SR_TRANSFER_BIT];

    // Condition decode; aliases share the same test
    always_comb begin
        cond.is_branch = 1'b1;
        cond.taken     = 1'b0;
        unique case (cond.op)
            OP_NONE: begin
                cond.is_branch = 1'b0;
            end
            OP_BRANCH_CARRY_SET,
            OP_BRANCH_UNSIGNED_LOWER:     cond.taken = (c_flag == 1'b1);
            OP_BRANCH_CARRY_CLEAR,
            OP_BRANCH_SAME_OR_HIGHER:     cond.taken = (c_flag == 1'b0);
            OP_BRANCH_NEGATIVE:           cond.taken = (n_flag == 1'b1);
            OP_BRANCH_POSITIVE:           cond.taken = (n_flag == 1'b0);
            OP_BRANCH_SIGNED_GE:          cond.taken = ((n_flag ^ v_flag) == 1'b0);
            OP_BRANCH_SIGNED_LT:          cond.taken = ((n_flag ^ v_flag) == 1'b1);
            OP_BRANCH_HALF_CARRY_SET:     cond.taken = (h_flag == 1'b1);
            OP_BRANCH_HALF_CARRY_CLEAR:   cond.taken = (h_flag == 1'b0);
            OP_BRANCH_TRANSFER_BIT_SET:   cond.taken = (t_flag == 1'b1);
            OP_BRANCH_TRANSFER_BIT_CLEAR: cond.taken = (t_flag == 1'b0);
            OP_BRANCH_OVERFLOW_SET:       cond.taken = (v_flag == 1'b1);
            default: begin
                // Illegal encodings are treated as no branch
                cond.is_branch = 1'b0;
            end
        endcase
    end

endmodule : branch_cond_eval

`default_nettype wire

//--- branch_target_calc.sv
// Target adder: program counter plus sign-extended offset plus one.
// Assumes the program counter wraps modulo its width.
`timescale 1ns/100ps
`default_nettype none
`include "branch_defines.svh"

module branch_target_calc #(
    parameter int PC_WIDTH     = `PC_WIDTH_DEFAULT,
    parameter int OFFSET_WIDTH = `OFFSET_WIDTH_DEFAULT
) (
    input  wire logic [PC_WIDTH-1:0]     pc,
    input  wire logic [OFFSET_WIDTH-1:0] offset,
    output logic      [PC_WIDTH-1:0]     sequential,
    output logic      [PC_WIDTH-1:0]     target
);

    // Sign extension keeps backward branches reachable
    function automatic logic [PC_WIDTH-1:0] sext(input logic [OFFSET_WIDTH-1:0] k);
        sext = {{(PC_WIDTH-OFFSET_WIDTH){k[OFFSET_WIDTH-1]}}, k};
    endfunction : sext

    // Both results modulo the counter width
    assign sequential = pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
    assign target     = pc + sext(offset) + {{(PC_WIDTH-1){1'b0}}, 1'b1};

endmodule : branch_target_calc

`default_nettype wire

//--- conditional_branch_unit.sv
// Conditional relative-branch unit: evaluates flags, steps or loads the PC.
// Assumes decode presents one operation with its offset on an accepted strobe,
// and that the status byte is stable while the unit is busy.
`timescale 1ns/100ps
`default_nettype none
`include "branch_defines.svh"

module conditional_branch_unit
    import branch_pkg::*;
#(
    parameter int PC_WIDTH     = `PC_WIDTH_DEFAULT,
    parameter int OFFSET_WIDTH = `OFFSET_WIDTH_DEFAULT
) (
    // Clock and reset
    input  wire logic                    MCLK,
    input  wire logic                    SRST,
    // Instruction from decode
    input  wire logic                    INSTR_VALID,
    input  wire branch_op_t              INSTR_OP,
    input  wire logic [OFFSET_WIDTH-1:0] INSTR_OFFSET,
    output logic                         INSTR_READY,
    // Status register
    input  wire logic [7:0]              STATUS_IN,
    output logic [7:0]                   STATUS_OUT,
    output logic                         STATUS_WE,
    // Program counter
    output logic [PC_WIDTH-1:0]          PC,
    // Completion report
    output logic                         DONE,
    output logic                         TAKEN
);

    // Parameters the adder cannot serve; refused while elaborating, not at run time
    if (PC_WIDTH < 2 || PC_WIDTH > 32 ||
        OFFSET_WIDTH < 2 || OFFSET_WIDTH >= PC_WIDTH) begin : g_bad_width
        $error("conditional_branch_unit: unsupported PC_WIDTH or OFFSET_WIDTH");
    end

    branch_state_t         state;
    logic                  accept;
    logic [PC_WIDTH-1:0]   pc_sequential;
    logic [PC_WIDTH-1:0]   pc_target;
    logic [PC_WIDTH-1:0]   held_target;

    branch_cond_if cond ();

    // Condition evaluation on the live flags
    assign cond.op     = INSTR_OP;
    assign cond.status = STATUS_IN;

    branch_cond_eval u_eval (
        .cond (cond)
    );

    branch_target_calc #(
        .PC_WIDTH     (PC_WIDTH),
        .OFFSET_WIDTH (OFFSET_WIDTH)
    ) u_target (
        .pc         (PC),
        .offset     (INSTR_OFFSET),
        .sequential (pc_sequential),
        .target     (pc_target)
    );

    // Busy during the second cycle of a taken branch
    assign INSTR_READY = (state == ST_IDLE);
    assign accept      = INSTR_VALID && INSTR_READY;

    // This unit never writes flags; outputs pass status through unchanged
    assign STATUS_OUT = STATUS_IN;
    assign STATUS_WE  = 1'b0;

    // Sequencer: taken branches spend one extra cycle
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (accept && cond.is_branch && cond.taken) begin
                        state <= ST_TAKEN_SECOND;
                    end
                end
                ST_TAKEN_SECOND: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Target captured at acceptance, loaded in the second cycle
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            held_target <= '0;
        end else if (accept && cond.is_branch && cond.taken) begin
            held_target <= pc_target;
        end
    end

    // Program counter update
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            PC <= PC_WIDTH'(`PC_RESET_VALUE);
        end else if (state == ST_TAKEN_SECOND) begin
            PC <= held_target;
        end else if (accept && cond.is_branch && !cond.taken) begin
            PC <= pc_sequential;
        end
    end

    // Completion pulse and result, registered
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            DONE  <= 1'b0;
            TAKEN <= 1'b0;
        end else begin
            DONE  <= (state == ST_TAKEN_SECOND) || (accept && cond.is_branch && !cond.taken);
            TAKEN <= (state == ST_TAKEN_SECOND);
        end
    end

endmodule : conditional_branch_unit

`default_nettype wire

//--- conditional_branch_unit_properties.sv
// Concurrent checks on the ports of the conditional branch unit.
// Assumes it is bound to every instance of the unit, parameters passed on.
`timescale 1ns/100ps
`default_nettype none
module conditional_branch_unit_checker
    import branch_pkg::*;
#(
    parameter int PC_WIDTH     = 16,
    parameter int OFFSET_WIDTH = 7
) (
    // Clock and reset
    input wire logic                    MCLK,
    input wire logic                    SRST,
    // Decode side
    input wire logic                    INSTR_VALID,
    input wire branch_op_t              INSTR_OP,
    input wire logic [OFFSET_WIDTH-1:0] INSTR_OFFSET,
    input wire logic                    INSTR_READY,
    // Status and program counter
    input wire logic [7:0]              STATUS_IN,
    input wire logic [7:0]              STATUS_OUT,
    input wire logic                    STATUS_WE,
    input wire logic [PC_WIDTH-1:0]     PC,
    input wire logic                    DONE,
    input wire logic                    TAKEN
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    // Accepted branch; illegal codes never count as a request
    wire logic acc = INSTR_VALID && INSTR_READY && INSTR_OP != OP_NONE
                     && INSTR_OP <= OP_BRANCH_OVERFLOW_SET;
    logic [7:0] sq;
    // Flags as seen at the accepting edge
    always_ff @(posedge MCLK) sq <= STATUS_IN;

    sequence s_taken; acc ##1 !INSTR_READY; endsequence
    sequence s_skip; acc ##1 INSTR_READY; endsequence
    // A taken branch stalls decode for one cycle; f is the taking condition
    property p_dec(branch_op_t o, logic f); acc && INSTR_OP == o |=> INSTR_READY == !f; endproperty

    a_carry_set: assert property (p_dec(OP_BRANCH_CARRY_SET, sq[0]))
        else $error("carry set decision wrong");
    a_carry_clear: assert property (p_dec(OP_BRANCH_CARRY_CLEAR, !sq[0]))
        else $error("carry clear decision wrong");
    a_minus_branch: assert property (p_dec(OP_BRANCH_NEGATIVE, sq[2]))
        else $error("negative decision wrong");
    a_plus_branch: assert property (p_dec(OP_BRANCH_POSITIVE, !sq[2]))
        else $error("positive decision wrong");
    a_signed_ge: assert property (p_dec(OP_BRANCH_SIGNED_GE, !(sq[2] ^ sq[3])))
        else $error("signed ge decision wrong");
    a_signed_lt: assert property (p_dec(OP_BRANCH_SIGNED_LT, sq[2] ^ sq[3]))
        else $error("signed lt decision wrong");
    a_hcarry_set: assert property (p_dec(OP_BRANCH_HALF_CARRY_SET, sq[5]))
        else $error("half carry set decision wrong");
    a_hcarry_clear: assert property (p_dec(OP_BRANCH_HALF_CARRY_CLEAR, !sq[5]))
        else $error("half carry clear decision wrong");
    a_tbit_set: assert property (p_dec(OP_BRANCH_TRANSFER_BIT_SET, sq[6]))
        else $error("transfer set decision wrong");
    a_tbit_clear: assert property (p_dec(OP_BRANCH_TRANSFER_BIT_CLEAR, !sq[6]))
        else $error("transfer clear decision wrong");
    a_overflow_set: assert property (p_dec(OP_BRANCH_OVERFLOW_SET, sq[3]))
        else $error("overflow decision wrong");
    a_taken_target: assert property (s_taken |=> DONE && TAKEN
        && PC == $past(PC, 2) + PC_WIDTH'($signed($past(INSTR_OFFSET, 2))) + 1'b1)
        else $error("taken target wrong");
    a_skip_step: assert property (s_skip |-> DONE && !TAKEN && PC == $past(PC) + 1'b1)
        else $error("fall through wrong");
    a_flags_kept: assert property (!STATUS_WE && STATUS_OUT == STATUS_IN) else $error("flags");
endmodule : conditional_branch_unit_checker

bind conditional_branch_unit conditional_branch_unit_checker #(.PC_WIDTH(PC_WIDTH),
    .OFFSET_WIDTH(OFFSET_WIDTH)) u_chk (.MCLK(MCLK), .SRST(SRST), .INSTR_VALID(INSTR_VALID),
    .INSTR_OP(INSTR_OP), .INSTR_OFFSET(INSTR_OFFSET), .INSTR_READY(INSTR_READY),
    .STATUS_IN(STATUS_IN), .STATUS_OUT(STATUS_OUT), .STATUS_WE(STATUS_WE), .PC(PC),
    .DONE(DONE), .TAKEN(TAKEN));
`default_nettype wire

//--- conditional_branch_unit_tb_top.sv
// Self-checking random bench for the conditional branch unit.
// Assumes the checker file binds itself to the unit.
`timescale 1ns/100ps
`default_nettype none
module conditional_branch_unit_tb_top
    import branch_pkg::*;
;
    logic       MCLK = 1'b0;
    logic       SRST = 1'b1;
    logic       INSTR_VALID = 1'b0;
    branch_op_t INSTR_OP = OP_NONE;
    logic [6:0] INSTR_OFFSET = 7'h00;
    logic [7:0] STATUS_IN = 8'h00;
    logic       INSTR_READY, STATUS_WE, DONE, TAKEN;
    logic [7:0] STATUS_OUT;
    logic [15:0] PC;
    logic [15:0] exp_pc = 16'h0000;
    logic [7:0] sts [3] = '{8'h00, 8'hFF, 8'h04};
    branch_op_t bad [2] = '{OP_NONE, branch_op_t'(4'hF)};
    int         fails = 0;
    int         n_tests = 0;
    int         cyc = 0;

    conditional_branch_unit u_conditional_branch_unit (.MCLK(MCLK), .SRST(SRST),
        .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP), .INSTR_OFFSET(INSTR_OFFSET),
        .INSTR_READY(INSTR_READY), .STATUS_IN(STATUS_IN), .STATUS_OUT(STATUS_OUT),
        .STATUS_WE(STATUS_WE), .PC(PC), .DONE(DONE), .TAKEN(TAKEN));

    // 25 MHz core clock
    always #20 MCLK = ~MCLK;
    // Hang guard, far above the at most 704 cycles the run needs
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Expected decision of each branch from the flags
    function automatic logic exp_t(branch_op_t op, logic [7:0] s);
        case (op)
            OP_BRANCH_CARRY_SET, OP_BRANCH_UNSIGNED_LOWER: return s[0];
            OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: return !s[0];
            OP_BRANCH_NEGATIVE: return s[2];
            OP_BRANCH_POSITIVE: return !s[2];
            OP_BRANCH_SIGNED_GE: return !(s[2] ^ s[3]);
            OP_BRANCH_SIGNED_LT: return s[2] ^ s[3];
            OP_BRANCH_HALF_CARRY_SET: return s[5];
            OP_BRANCH_HALF_CARRY_CLEAR: return !s[5];
            OP_BRANCH_TRANSFER_BIT_SET: return s[6];
            OP_BRANCH_TRANSFER_BIT_CLEAR: return !s[6];
            OP_BRANCH_OVERFLOW_SET: return s[3];
            default: return 1'b0;
        endcase
    endfunction : exp_t

    // Valid stays high, so a not-taken branch is followed back to back
    task automatic run(input branch_op_t op, input logic [6:0] k, input logic [7:0] s);
        logic t;
        t = exp_t(op, s);
        INSTR_VALID = 1'b1;
        INSTR_OP = op;
        INSTR_OFFSET = k;
        STATUS_IN = s;
        @(posedge MCLK);
        #1;
        check(STATUS_WE, 1'b0);
        if (t) begin
            check(INSTR_READY, 1'b0);
            @(posedge MCLK);
            #1;
            exp_pc = exp_pc + {{9{k[6]}}, k} + 16'h0001;
        end else begin
            check(INSTR_READY, 1'b1);
            exp_pc = exp_pc + 16'h0001;
        end
        check(DONE, 1'b1);
        check(TAKEN, t);
        check(PC, exp_pc);
        check(STATUS_OUT, s);
    endtask : run

    task automatic finish_test();
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // Extreme offsets first, then every operation, then random traffic
    initial begin
        void'($urandom(32'h673D322F));
        repeat (20) @(posedge MCLK);
        #1;
        SRST = 1'b0;
        check(PC, 16'h0000);
        run(OP_BRANCH_CARRY_SET, 7'h40, 8'h01);
        run(OP_BRANCH_UNSIGNED_LOWER, 7'h3F, 8'h01);
        for (int o = 1; o <= 13; o++) begin
            foreach (sts[j]) run(branch_op_t'(o[3:0]), 7'h05, sts[j]);
        end
        repeat (300) run(branch_op_t'(4'($urandom_range(13, 1))), 7'($urandom), 8'($urandom));
        foreach (bad[i]) begin
            INSTR_OP = bad[i];
            @(posedge MCLK);
            #1;
            check(DONE, 1'b0);
            check(PC, exp_pc);
        end
        finish_test();
    end
endmodule : conditional_branch_unit_tb_top
`default_nettype wire
